//--- include/fmrp_consts.svh
// Constants of the flash mode block.
`ifndef FMRP_CONSTS_SVH
`define FMRP_CONSTS_SVH
`define FMRP_OP_ENTER_QUAD 8'h38
`define FMRP_OP_EXIT_QUAD 8'hff
`define FMRP_OP_RST_ARM 8'h66
`define FMRP_OP_RST_GO 8'h99
`define FMRP_OP_UDPD 8'h79
`define FMRP_OP_DPD 8'hb9
`define FMRP_OP_DPD_WAKE 8'hab
`define FMRP_CLK_PERIOD_NS 20
`define FMRP_T_RESET_NS 28000
`define FMRP_T_UDPD_EXIT_NS 1000
`define FMRP_T_WAKE_LOW_NS 200
`define FMRP_SYNC_LAG 4
`define FMRP_SCK_HALF 4
`define FMRP_RST_PARAMS 8'h00
`define FMRP_RST_WRAP 3'h0
`define FMRP_REG_CMD 4'h0
`define FMRP_REG_STATUS 4'h4
`define FMRP_CMD_QUAD_BIT 8
`define FMRP_CMD_WAKE_BIT 16
`endif

//--- include/fmrp_pkg.sv
// Types of the flash mode block: device power states and host controller states.
package fmrp_pkg;
   typedef enum logic [2:0] {
      FMRP_STANDBY = 3'h0,
      FMRP_DPD = 3'h1,
      FMRP_UDPD = 3'h3,
      FMRP_UDPD_EXIT = 3'h2,
      FMRP_RESETTING = 3'h6
   } fmrp_pwr_t;
   typedef enum logic [2:0] {
      FMRP_H_IDLE = 3'h0,
      FMRP_H_SHIFT = 3'h1,
      FMRP_H_CLOSE = 3'h3,
      FMRP_H_HOLD = 3'h2,
      FMRP_H_WAKE = 3'h6
   } fmrp_hst_t;
endpackage : fmrp_pkg

//--- include/fmrp_if.sv
// Serial flash link between the host controller and the flash mode logic.
`timescale 1ns/100ps
interface fmrp_if;
   logic cs_n;
   logic sclk;
   logic [3:0] dq;
   modport host (output cs_n, output sclk, output dq);
   modport dev (input cs_n, input sclk, input dq);
endinterface : fmrp_if

//--- hw/fmrp_dev.sv
// Flash side mode, reset and power-down logic.
// Contract
// - Opcode FFh in quad mode exits to SPI.
// - Quad exit keeps latch, suspend, wrap setting.
// - Accepted reset restores all volatile power-on defaults.
// - Reset only on 66h directly followed by 99h.
// - Other instruction after 66h disarms the reset.
// - 28us recovery after reset; commands are ignored.
// - Host checks busy and suspend before reset; fmrp_host checks neither busy_in nor suspend_flag.
// - Ultra-deep power-down ignores every instruction.
// - Ultra-deep entry is opcode 79h from deep power-down.
// - Enter ultra-deep power-down promptly after select rises.
// - Off-byte-boundary entry frame aborts to standby.
// - Power cycle always starts in standby.
// - Entry opcode ignored while program or erase runs.
// - Long select-low pulse wakes; clocked byte ignored.
// - Frames during exit time are ignored.
// - Only 38h enters quad mode; modes exclusive.
// - Enter-quad ignored unless quad enable set.
// - Power-up starts in SPI mode.
`timescale 1ns/100ps
`include "fmrp_consts.svh"
module fmrp_dev #(
   parameter int unsigned RST_CYC = `FMRP_T_RESET_NS / `FMRP_CLK_PERIOD_NS,
   parameter int unsigned EXIT_CYC = `FMRP_T_UDPD_EXIT_NS / `FMRP_CLK_PERIOD_NS,
   parameter int unsigned WAKE_CYC = (`FMRP_T_WAKE_LOW_NS + `FMRP_CLK_PERIOD_NS - 1) / `FMRP_CLK_PERIOD_NS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   fmrp_if.dev link,
   input wire logic quad_enable_bit,
   input wire logic busy_in,
   input wire logic wel_set,
   input wire logic wel_clr,
   input wire logic sus_set,
   input wire logic sus_clr,
   input wire logic param_we,
   input wire logic [7:0] param_wdata,
   input wire logic wrap_we,
   input wire logic [2:0] wrap_wdata,
   output logic quad_command_mode,
   output logic write_enable_latch,
   output logic suspend_flag,
   output logic [7:0] read_parameter_bits,
   output logic [2:0] wrap_setting_bits,
   output logic reset_armed,
   output logic abort_pulse,
   output logic cmd_valid,
   output logic [7:0] cmd_opcode,
   output fmrp_pkg::fmrp_pwr_t power_state
);
   localparam int unsigned MAXC = (RST_CYC > EXIT_CYC) ? ((RST_CYC > WAKE_CYC) ? RST_CYC : WAKE_CYC) :
      ((EXIT_CYC > WAKE_CYC) ? EXIT_CYC : WAKE_CYC);
   localparam int unsigned CW = $clog2(MAXC + 1);

   if (RST_CYC < 1 || EXIT_CYC < 1 || WAKE_CYC < 1) begin : g_bad
      $error("Bad timing counts.");
   end

   logic [5:0] s1_q, s2_q, s3_q, flt_q;
   logic cs_p_q, ck_p_q;
   logic cs_n, ck;
   logic [3:0] dq;
   logic fall, rise, ck_rise;
   logic [7:0] op_q;
   logic [2:0] bit_q;
   logic [2:0] step;
   logic full_q, skip_q;
   logic [CW-1:0] low_q, cnt_q;
   logic cmd, wrap_dflt, do_reset, armed_q, qm_q;
   fmrp_pkg::fmrp_pwr_t st_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 6'h3f;
         s2_q <= 6'h3f;
         s3_q <= 6'h3f;
         flt_q <= 6'h3f;
      end else begin
         s1_q <= {link.dq, link.sclk, link.cs_n};
         s2_q <= s1_q;
         s3_q <= s2_q;
         flt_q <= (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
      end
   end

   assign cs_n = flt_q[0];
   assign ck = flt_q[1];
   assign dq = flt_q[5:2];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cs_p_q <= 1'b1;
         ck_p_q <= 1'b0;
      end else begin
         cs_p_q <= cs_n;
         ck_p_q <= ck;
      end
   end

   assign fall = cs_p_q & ~cs_n;
   assign rise = ~cs_p_q & cs_n;
   assign ck_rise = ck & ~ck_p_q & ~cs_n;
   assign step = qm_q ? 3'h4 : 3'h1;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= 8'h00;
         bit_q <= 3'h0;
         full_q <= 1'b0;
      end else if (fall) begin
         bit_q <= 3'h0;
         full_q <= 1'b0;
      end else if (ck_rise) begin
         bit_q <= bit_q + step;
         if (!full_q) begin
            op_q <= qm_q ? {op_q[3:0], dq} : {op_q[6:0], dq[0]};
            if (3'(bit_q + step) == 3'h0) begin
               full_q <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         skip_q <= 1'b0;
      end else if (fall) begin
         skip_q <= (st_q != fmrp_pkg::FMRP_STANDBY) && (st_q != fmrp_pkg::FMRP_DPD);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         low_q <= '0;
      end else if (fall) begin
         low_q <= '0;
      end else if (!cs_n && low_q != CW'(MAXC)) begin
         low_q <= low_q + 1'b1;
      end
   end

   assign cmd = rise & full_q & ~skip_q & (st_q == fmrp_pkg::FMRP_STANDBY);
   assign do_reset = cmd & armed_q & (op_q == `FMRP_OP_RST_GO);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (cmd) begin
         armed_q <= (op_q == `FMRP_OP_RST_ARM);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= fmrp_pkg::FMRP_STANDBY;
         cnt_q <= '0;
      end else begin
         case (st_q)
            fmrp_pkg::FMRP_STANDBY: begin
               if (do_reset) begin
                  st_q <= fmrp_pkg::FMRP_RESETTING;
                  cnt_q <= CW'(RST_CYC);
               end else if (cmd && op_q == `FMRP_OP_DPD) begin
                  st_q <= fmrp_pkg::FMRP_DPD;
               end
            end
            fmrp_pkg::FMRP_DPD: begin
               if (rise && full_q && !skip_q) begin
                  if (op_q == `FMRP_OP_UDPD && !busy_in) begin
                     if (bit_q == 3'h0) begin
                        st_q <= fmrp_pkg::FMRP_UDPD;
                     end else begin
                        st_q <= fmrp_pkg::FMRP_STANDBY;
                     end
                  end else if (op_q == `FMRP_OP_DPD_WAKE) begin
                     st_q <= fmrp_pkg::FMRP_STANDBY;
                  end
               end
            end
            fmrp_pkg::FMRP_UDPD: begin
               if (rise && low_q >= CW'(WAKE_CYC)) begin
                  st_q <= fmrp_pkg::FMRP_UDPD_EXIT;
                  cnt_q <= CW'(EXIT_CYC);
               end
            end
            fmrp_pkg::FMRP_UDPD_EXIT: begin
               if (cnt_q <= CW'(1)) begin
                  st_q <= fmrp_pkg::FMRP_STANDBY;
               end
               cnt_q <= cnt_q - 1'b1;
            end
            fmrp_pkg::FMRP_RESETTING: begin
               if (cnt_q <= CW'(1)) begin
                  st_q <= fmrp_pkg::FMRP_STANDBY;
               end
               cnt_q <= cnt_q - 1'b1;
            end
            default: begin
               st_q <= fmrp_pkg::FMRP_STANDBY;
            end
         endcase
      end
   end

   assign wrap_dflt = cmd & ~qm_q & quad_enable_bit & (op_q == `FMRP_OP_ENTER_QUAD);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         qm_q <= 1'b0;
      end else if (do_reset) begin
         qm_q <= 1'b0;
      end else if (wrap_dflt) begin
         qm_q <= 1'b1;
      end else if (cmd && qm_q && op_q == `FMRP_OP_EXIT_QUAD) begin
         qm_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         write_enable_latch <= 1'b0;
         suspend_flag <= 1'b0;
      end else if (do_reset) begin
         write_enable_latch <= 1'b0;
         suspend_flag <= 1'b0;
      end else begin
         if (wel_set) begin
            write_enable_latch <= 1'b1;
         end else if (wel_clr) begin
            write_enable_latch <= 1'b0;
         end
         if (sus_set) begin
            suspend_flag <= 1'b1;
         end else if (sus_clr) begin
            suspend_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         read_parameter_bits <= `FMRP_RST_PARAMS;
         wrap_setting_bits <= `FMRP_RST_WRAP;
      end else if (do_reset) begin
         read_parameter_bits <= `FMRP_RST_PARAMS;
         wrap_setting_bits <= `FMRP_RST_WRAP;
      end else begin
         if (param_we) begin
            read_parameter_bits <= param_wdata;
         end
         if (wrap_dflt) begin
            wrap_setting_bits <= `FMRP_RST_WRAP;
         end else if (wrap_we) begin
            wrap_setting_bits <= wrap_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_valid <= 1'b0;
         cmd_opcode <= 8'h00;
         abort_pulse <= 1'b0;
      end else begin
         cmd_valid <= cmd;
         abort_pulse <= do_reset;
         if (cmd) begin
            cmd_opcode <= op_q;
         end
      end
   end

   assign quad_command_mode = qm_q;
   assign reset_armed = armed_q;
   assign power_state = st_q;
endmodule : fmrp_dev

//--- hw/fmrp_host.sv
// Host controller framing flash instructions over AXI4-Lite.
`timescale 1ns/100ps
`include "fmrp_consts.svh"
module fmrp_host #(
   parameter int unsigned SCK_HALF = `FMRP_SCK_HALF,
   parameter int unsigned RST_CYC = `FMRP_T_RESET_NS / `FMRP_CLK_PERIOD_NS,
   parameter int unsigned EXIT_CYC = `FMRP_T_UDPD_EXIT_NS / `FMRP_CLK_PERIOD_NS,
   parameter int unsigned WAKE_CYC = (`FMRP_T_WAKE_LOW_NS + `FMRP_CLK_PERIOD_NS - 1) / `FMRP_CLK_PERIOD_NS
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   fmrp_if.host link,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int unsigned HC = RST_CYC + EXIT_CYC + WAKE_CYC + 2 * `FMRP_SYNC_LAG + 2;
   localparam int unsigned CW = $clog2(HC + 1);
   localparam int unsigned DW = $clog2(SCK_HALF + 1);

   if (SCK_HALF < `FMRP_SCK_HALF || RST_CYC < 1 || EXIT_CYC < 1 || WAKE_CYC < 1) begin : g_bad
      $error("Bad parameters.");
   end

   logic aw_q, w_q;
   logic [3:0] awa_q;
   logic [31:0] wd_q, cmd_q;
   logic wr, go, busy, hold;
   fmrp_pkg::fmrp_hst_t st_q;
   logic [DW-1:0] div_q;
   logic tick;
   logic [31:0] sh_q, sh_d;
   logic [6:0] clk_q;
   logic quad_q, armed_q, rst_go_q;
   logic [CW-1:0] cnt_q;
   logic cs_n_q, sclk_q;
   logic [3:0] dq_q;

   assign s_axi_awready = ~aw_q;
   assign s_axi_wready = ~w_q;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr = aw_q & w_q & ~s_axi_bvalid;
   assign busy = st_q != fmrp_pkg::FMRP_H_IDLE;
   assign hold = st_q == fmrp_pkg::FMRP_H_HOLD;
   assign go = wr & (awa_q == `FMRP_REG_CMD) & ~busy & (&s_axi_wstrb[2:0]);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 4'h0;
         wd_q <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && !aw_q) begin
            aw_q <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_q) begin
            w_q <= 1'b1;
            wd_q <= s_axi_wdata;
         end
         if (wr) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= go ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         if (s_axi_araddr == `FMRP_REG_CMD) begin
            s_axi_rdata <= cmd_q;
         end else if (s_axi_araddr == `FMRP_REG_STATUS) begin
            s_axi_rdata <= {29'h0, armed_q, hold, busy};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= 32'h0000_0000;
      end else if (go) begin
         cmd_q <= {15'h0, wd_q[16:0]};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= '0;
      end else if (!busy || div_q == DW'(SCK_HALF - 1)) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   assign tick = busy & (div_q == DW'(SCK_HALF - 1));

   always_comb begin
      sh_d = sh_q;
      if (go) begin
         sh_d = {wd_q[7:0], 24'h00_0000};
      end else if (st_q == fmrp_pkg::FMRP_H_SHIFT && tick && sclk_q) begin
         sh_d = quad_q ? {sh_q[27:0], 4'h0} : {sh_q[30:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= fmrp_pkg::FMRP_H_IDLE;
         sh_q <= 32'h0000_0000;
         clk_q <= 7'h00;
         quad_q <= 1'b0;
         cnt_q <= '0;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         dq_q <= 4'h0;
         armed_q <= 1'b0;
         rst_go_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         dq_q <= quad_q ? sh_d[31:28] : {3'h0, sh_d[31]};
         case (st_q)
            fmrp_pkg::FMRP_H_IDLE: begin
               if (go && wd_q[`FMRP_CMD_WAKE_BIT]) begin
                  cs_n_q <= 1'b0;
                  cnt_q <= CW'(WAKE_CYC + `FMRP_SYNC_LAG);
                  st_q <= fmrp_pkg::FMRP_H_WAKE;
               end else if (go) begin
                  cs_n_q <= 1'b0;
                  quad_q <= wd_q[`FMRP_CMD_QUAD_BIT];
                  dq_q <= wd_q[`FMRP_CMD_QUAD_BIT] ? wd_q[7:4] : {3'h0, wd_q[7]};
                  clk_q <= (wd_q[15:9] != 7'h00) ? wd_q[15:9] : (wd_q[`FMRP_CMD_QUAD_BIT] ? 7'h02 : 7'h08);
                  rst_go_q <= armed_q && wd_q[7:0] == `FMRP_OP_RST_GO;
                  armed_q <= wd_q[7:0] == `FMRP_OP_RST_ARM;
                  st_q <= fmrp_pkg::FMRP_H_SHIFT;
               end
            end
            fmrp_pkg::FMRP_H_SHIFT: begin
               if (tick) begin
                  sclk_q <= ~sclk_q;
                  if (sclk_q) begin
                     clk_q <= clk_q - 1'b1;
                     if (clk_q == 7'h01) begin
                        st_q <= fmrp_pkg::FMRP_H_CLOSE;
                     end
                  end
               end
            end
            fmrp_pkg::FMRP_H_CLOSE: begin
               if (tick) begin
                  cs_n_q <= 1'b1;
                  cnt_q <= CW'(RST_CYC + 2 * `FMRP_SYNC_LAG);
                  st_q <= rst_go_q ? fmrp_pkg::FMRP_H_HOLD : fmrp_pkg::FMRP_H_IDLE;
               end
            end
            fmrp_pkg::FMRP_H_WAKE: begin
               cnt_q <= cnt_q - 1'b1;
               if (cnt_q == CW'(1)) begin
                  cs_n_q <= 1'b1;
                  cnt_q <= CW'(EXIT_CYC + 2 * `FMRP_SYNC_LAG);
                  st_q <= fmrp_pkg::FMRP_H_HOLD;
               end
            end
            fmrp_pkg::FMRP_H_HOLD: begin
               cnt_q <= cnt_q - 1'b1;
               rst_go_q <= 1'b0;
               if (cnt_q <= CW'(1)) begin
                  st_q <= fmrp_pkg::FMRP_H_IDLE;
               end
            end
            default: begin
               st_q <= fmrp_pkg::FMRP_H_IDLE;
            end
         endcase
      end
   end

   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign link.dq = dq_q;
endmodule : fmrp_host

//--- dv/fmrp_props.sv
// Checker of the flash mode block.
`timescale 1ns/100ps
module fmrp_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic quad_enable_bit,
   input wire logic busy_in,
   input wire logic quad_command_mode,
   input wire logic write_enable_latch,
   input wire logic suspend_flag,
   input wire logic [7:0] read_parameter_bits,
   input wire logic [2:0] wrap_setting_bits,
   input wire logic reset_armed,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_opcode,
   input wire fmrp_pkg::fmrp_pwr_t power_state
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sclk_idle_a: assert property (cs_n |-> !sclk) else $error("serial clock outside a frame");
   power_up_a: assert property ($rose(rst_n) |-> power_state == fmrp_pkg::FMRP_STANDBY && !quad_command_mode)
      else $error("bad power-up state");
   quad_gate_a: assert property ($rose(quad_command_mode) |-> $past(quad_enable_bit) && cmd_opcode == 8'h38)
      else $error("bad quad entry");
   quad_keep_a: assert property ($fell(quad_command_mode) && $past(power_state) == fmrp_pkg::FMRP_STANDBY
      && power_state == fmrp_pkg::FMRP_STANDBY |-> cmd_opcode == 8'hff && $stable(write_enable_latch)
      && $stable(suspend_flag) && $stable(wrap_setting_bits)) else $error("quad exit changed settings");
   reset_clear_a: assert property ($past(power_state) == fmrp_pkg::FMRP_RESETTING
      && power_state == fmrp_pkg::FMRP_STANDBY |-> !write_enable_latch && !suspend_flag && !quad_command_mode
      && read_parameter_bits == 8'h00 && wrap_setting_bits == 3'h0) else $error("settings kept over reset");
   reset_pair_a: assert property (power_state == fmrp_pkg::FMRP_RESETTING
      && $past(power_state) != fmrp_pkg::FMRP_RESETTING |-> cmd_opcode == 8'h99 && $past(reset_armed))
      else $error("reset without arming");
   disarm_a: assert property (cmd_valid && cmd_opcode != 8'h66 |-> ##[0:1] !reset_armed)
      else $error("still armed");
   quiet_reset_a: assert property (power_state == fmrp_pkg::FMRP_RESETTING
      && $past(power_state) == fmrp_pkg::FMRP_RESETTING |-> !cmd_valid) else $error("command during reset");
   quiet_udpd_a: assert property (power_state inside {fmrp_pkg::FMRP_UDPD, fmrp_pkg::FMRP_UDPD_EXIT}
      && $past(power_state) != fmrp_pkg::FMRP_STANDBY |-> !cmd_valid) else $error("command in power down");
   udpd_entry_a: assert property (power_state == fmrp_pkg::FMRP_UDPD && $past(power_state) != fmrp_pkg::FMRP_UDPD
      |-> $past(power_state) == fmrp_pkg::FMRP_DPD && !$past(busy_in)) else $error("bad power down entry");
   wake_a: assert property (power_state == fmrp_pkg::FMRP_UDPD_EXIT && $past(power_state) != power_state
      |-> $past(power_state) == fmrp_pkg::FMRP_UDPD) else $error("exit not from power down");
endmodule : fmrp_props

//--- dv/test_flash_mode_reset_powerdown_ctrl.sv
// Bench of the flash mode block.
`timescale 1ns/100ps
`include "fmrp_consts.svh"
module test_flash_mode_reset_powerdown_ctrl;
   localparam int unsigned RC = 40, XC = 50, WC = 20;
   logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, quad_enable_bit, busy_in, wel_set, wel_clr;
   logic sus_set, sus_clr, param_we, wrap_we, quad_command_mode, write_enable_latch, suspend_flag, reset_armed;
   logic abort_pulse, cmd_valid;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] param_wdata, read_parameter_bits, cmd_opcode, wire_byte;
   logic [2:0] wrap_wdata, wrap_setting_bits;
   fmrp_pkg::fmrp_pwr_t power_state;
   int mismatches = 0, n_tests = 0, wire_bits = 0, aborts = 0;
   fmrp_if link_if();
   fmrp_host #(.RST_CYC(RC), .EXIT_CYC(XC), .WAKE_CYC(WC)) fmrp_host_inst (.clk_sys, .rst_n, .link(link_if),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   fmrp_dev #(.RST_CYC(RC), .EXIT_CYC(XC), .WAKE_CYC(WC)) fmrp_dev_inst (.clk_sys, .rst_n, .link(link_if),
      .quad_enable_bit, .busy_in, .wel_set, .wel_clr, .sus_set, .sus_clr, .param_we, .param_wdata, .wrap_we,
      .wrap_wdata, .quad_command_mode, .write_enable_latch, .suspend_flag, .read_parameter_bits,
      .wrap_setting_bits, .reset_armed, .abort_pulse, .cmd_valid, .cmd_opcode, .power_state);
   fmrp_props fmrp_props_inst (.clk_sys, .rst_n, .cs_n(link_if.cs_n), .sclk(link_if.sclk), .quad_enable_bit,
      .busy_in, .quad_command_mode, .write_enable_latch, .suspend_flag, .read_parameter_bits, .wrap_setting_bits,
      .reset_armed, .cmd_valid, .cmd_opcode, .power_state);
   always @(posedge link_if.sclk) if (!link_if.cs_n) begin
      wire_byte <= {wire_byte[6:0], link_if.dq[0]};
      wire_bits <= wire_bits + 1;
   end
   always @(negedge link_if.cs_n) wire_bits <= 0;
   always @(posedge clk_sys) if (abort_pulse === 1'b1) aborts <= aborts + 1;
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic logic exp_quad(input logic cur, input logic qe, input logic [7:0] op);
      if (!cur && qe && op == 8'h38) return 1'b1;
      if (cur && op == 8'hff) return 1'b0;
      return cur;
   endfunction : exp_quad
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      check("write wait", n < 200, 1);
      if (n >= 200) report_and_stop();
   endtask : axi_wr
   task automatic wait_clear(input logic [31:0] mask);
      int n = 0;
      do begin
         repeat (2) @(posedge clk_sys);
         s_axi_araddr <= `FMRP_REG_STATUS;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1 && n < 900);
         s_axi_rready <= 1'b0;
      end while ((s_axi_rdata & mask) !== 32'h0000_0000 && n < 900);
      check("status wait", n < 900, 1);
      if (n >= 900) report_and_stop();
      repeat (8) @(posedge clk_sys);
   endtask : wait_clear
   task automatic send(input logic [7:0] op, input logic q, input logic [6:0] clks, input logic wake);
      logic [1:0] r;
      axi_wr(`FMRP_REG_CMD, {15'h0000, wake, clks, q, op}, r);
      wait_clear(32'h0000_0001);
   endtask : send
   task automatic set_all();
      rnd = xs(rnd);
      wel_set <= 1'b1;
      sus_set <= 1'b1;
      wrap_we <= 1'b1;
      param_we <= 1'b1;
      wrap_wdata <= rnd[2:0] | 3'h1;
      param_wdata <= rnd[15:8] | 8'h01;
      @(posedge clk_sys);
      {wel_set, sus_set, wrap_we, param_we} <= 4'h0;
      @(posedge clk_sys);
   endtask : set_all
   task automatic state_is(input fmrp_pkg::fmrp_pwr_t s);
      check("power state", 32'(power_state), 32'(s));
   endtask : state_is
   initial begin
      logic [1:0] r;
      logic qm, qe;
      logic [7:0] op;
      rnd = 32'h0000_004f;
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, quad_enable_bit} = 7'h00;
      {busy_in, wel_set, wel_clr, sus_set, sus_clr, param_we, wrap_we} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, param_wdata, wrap_wdata} = '0;
      s_axi_wstrb = 4'hf;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      state_is(fmrp_pkg::FMRP_STANDBY);
      send(8'h38, 1'b0, 7'h00, 1'b0);
      check("quad without enable", quad_command_mode, 0);
      check("wire opcode", {wire_bits[23:0], wire_byte}, 32'h0000_0838);
      quad_enable_bit <= 1'b1;
      send(8'h38, 1'b0, 7'h00, 1'b0);
      check("quad entry", quad_command_mode, 1);
      set_all();
      send(8'hff, 1'b1, 7'h00, 1'b0);
      check("quad exit", {quad_command_mode, write_enable_latch, suspend_flag, wrap_setting_bits},
         {26'h0, 3'b011, wrap_wdata});
      qm = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         qe = rnd[8];
         op = rnd[9] ? (rnd[10] ? 8'hff : 8'h38) : {rnd[7:1], 1'b0};
         quad_enable_bit <= qe;
         send(op, qm, 7'h00, 1'b0);
         qm = exp_quad(qm, qe, op);
         check("random quad", quad_command_mode, qm);
         check("decoded opcode", cmd_opcode, op);
      end
      if (qm) send(8'hff, 1'b1, 7'h00, 1'b0);
      quad_enable_bit <= 1'b1;
      send(8'h38, 1'b0, 7'h05, 1'b0);
      check("partial opcode", {wire_bits[7:0], 7'h00, quad_command_mode}, 32'h0000_0500);
      send(8'h38, 1'b0, 7'h00, 1'b0);
      set_all();
      send(8'h66, 1'b1, 7'h00, 1'b0);
      send(8'h06, 1'b1, 7'h00, 1'b0);
      send(8'h99, 1'b1, 7'h00, 1'b0);
      check("disarmed", {power_state == fmrp_pkg::FMRP_STANDBY, write_enable_latch}, 2'b11);
      send(8'h66, 1'b1, 7'h00, 1'b0);
      axi_wr(`FMRP_REG_CMD, 32'h0000_0199, r);
      for (int n = 0; n < 300 && power_state != fmrp_pkg::FMRP_RESETTING; n++) @(posedge clk_sys);
      state_is(fmrp_pkg::FMRP_RESETTING);
      axi_wr(`FMRP_REG_CMD, 32'h0000_0006, r);
      check("command in recovery", r, 2'b10);
      wait_clear(32'h0000_0003);
      check("reset defaults", {quad_command_mode, write_enable_latch, suspend_flag, wrap_setting_bits,
         read_parameter_bits}, 32'h0000_0000);
      check("abort pulse", aborts, 1);
      send(8'hb9, 1'b0, 7'h00, 1'b0);
      busy_in <= 1'b1;
      send(8'h79, 1'b0, 7'h00, 1'b0);
      state_is(fmrp_pkg::FMRP_DPD);
      busy_in <= 1'b0;
      send(8'h79, 1'b0, 7'h0c, 1'b0);
      state_is(fmrp_pkg::FMRP_STANDBY);
      send(8'hb9, 1'b0, 7'h00, 1'b0);
      send(8'h79, 1'b0, 7'h10, 1'b0);
      state_is(fmrp_pkg::FMRP_UDPD);
      send(8'hab, 1'b0, 7'h01, 1'b0);
      state_is(fmrp_pkg::FMRP_UDPD);
      axi_wr(`FMRP_REG_CMD, 32'h0001_0000, r);
      for (int n = 0; n < 300 && power_state != fmrp_pkg::FMRP_UDPD_EXIT; n++) @(posedge clk_sys);
      state_is(fmrp_pkg::FMRP_UDPD_EXIT);
      wait_clear(32'h0000_0003);
      state_is(fmrp_pkg::FMRP_STANDBY);
      report_and_stop();
   end
endmodule : test_flash_mode_reset_powerdown_ctrl
